// File: design/board_watchdog_and_timers.v
// Board watchdog, long-duration timer and periodic rate timer,
// reached over APB. Assumes an APB master on the system clock and
// that wd_hw_enable_i is a board strap level synchronous to it.
`timescale 1ns/1ps
`include "board_timers_map.vh"

module board_watchdog_and_timers #(
    parameter RESET_PULSE_CYC = `BOARD_RESET_PULSE_CYC
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire reset_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire pready_o,
    output wire pslverr_o,
    output reg [31:0] prdata_o,
    // Board strap
    input wire wd_hw_enable_i,
    // Board outputs
    output reg nmi_o,
    output reg board_reset_o,
    output reg timer_irq_o
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire acc = psel_i && penable_i;
    wire wr = acc && pwrite_i;
    wire rd = acc && !pwrite_i;

    function mapped;
        input [11:0] a;
        begin
            case (a)
                `WD_CTRL_OFS, `WD_RESTART_OFS, `WD_TIMEOUT_OFS,
                `WD_STATUS_OFS, `LDT_HOLD_OFS, `LDT_CTRL_OFS,
                `LDT_COUNT_OFS, `PRT_CTRL_OFS, `TMR_STATUS_OFS,
                `TMR_IRQ_EN_OFS: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    function hit_wr;
        input [11:0] ofs;
        begin
            hit_wr = wr && paddr_i == ofs;
        end
    endfunction

    assign pready_o = 1'b1;
    assign pslverr_o = acc && !mapped(paddr_i);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg wd_run_r;
    reg wd_reset_mode_r;
    reg [31:0] wd_timeout_r;
    reg [31:0] wd_count_r;
    reg wd_nmi_seen_r;
    reg [31:0] ldt_hold_r;
    reg [31:0] ldt_count_r;
    reg ldt_run_r;
    reg [2:0] prt_rate_r;
    reg prt_en_r;
    reg ldt_flag_r;
    reg prt_flag_r;
    reg [1:0] irq_en_r;
    reg [7:0] rst_cnt_r;
    wire prt_tick;
    wire ldt_roll = ldt_run_r && ldt_count_r == 32'h0000_0000;
    wire wd_kick = hit_wr(`WD_RESTART_OFS) &&
        pwdata_i == `WD_RESTART_KEY;
    wire wd_active = wd_run_r && wd_hw_enable_i;
    wire wd_expire = wd_active && wd_count_r == 32'h0000_0000 &&
        !wd_kick;

    rate_divider u_rate_divider (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .enable_i(prt_en_r),
        .rate_sel_i(prt_rate_r),
        .tick_o(prt_tick)
    );

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wd_run_r <= 1'b0;
            wd_reset_mode_r <= 1'b0;
            wd_timeout_r <= `WD_TIMEOUT_RST;
            wd_count_r <= `WD_TIMEOUT_RST;
            wd_nmi_seen_r <= 1'b0;
            nmi_o <= 1'b0;
            board_reset_o <= 1'b0;
            rst_cnt_r <= 8'h00;
        end else begin
            if (hit_wr(`WD_CTRL_OFS)) begin
                wd_run_r <= pwdata_i[`WD_CTRL_RUN_BIT];
                wd_reset_mode_r <= pwdata_i[`WD_CTRL_RESET_MODE_BIT];
            end
            if (hit_wr(`WD_TIMEOUT_OFS)) begin
                wd_timeout_r <= pwdata_i;
            end
            // Reload on expiry too, so one expiry gives one action
            if (!wd_active || wd_kick || wd_expire) begin
                wd_count_r <= wd_timeout_r;
            end else if (wd_count_r != 32'h0000_0000) begin
                wd_count_r <= wd_count_r - 32'h0000_0001;
            end
            if (wd_expire && !wd_reset_mode_r) begin
                nmi_o <= 1'b1;
                wd_nmi_seen_r <= 1'b1;
            end else if (wd_kick || !wd_active) begin
                nmi_o <= 1'b0;
            end
            if (hit_wr(`WD_STATUS_OFS) && pwdata_i[`WD_STAT_NMI_BIT] &&
                !(wd_expire && !wd_reset_mode_r)) begin
                wd_nmi_seen_r <= 1'b0;
            end
            if (wd_expire && wd_reset_mode_r) begin
                rst_cnt_r <= RESET_PULSE_CYC[7:0];
                board_reset_o <= 1'b1;
            end else if (rst_cnt_r != 8'h00) begin
                rst_cnt_r <= rst_cnt_r - 8'h01;
                board_reset_o <= rst_cnt_r != 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Long-duration and periodic timers
    // ------------------------------------------------------------
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ldt_hold_r <= 32'h0000_0000;
            ldt_count_r <= 32'h0000_0000;
            ldt_run_r <= 1'b0;
            prt_rate_r <= 3'h0;
            prt_en_r <= 1'b0;
            ldt_flag_r <= 1'b0;
            prt_flag_r <= 1'b0;
            irq_en_r <= 2'h0;
            timer_irq_o <= 1'b0;
        end else begin
            if (hit_wr(`LDT_HOLD_OFS)) begin
                ldt_hold_r <= pwdata_i;
            end
            if (hit_wr(`LDT_CTRL_OFS)) begin
                ldt_run_r <= pwdata_i[`LDT_CTRL_START_BIT];
                ldt_count_r <= ldt_hold_r;
            end else if (ldt_roll) begin
                ldt_count_r <= ldt_hold_r;
            end else if (ldt_run_r) begin
                ldt_count_r <= ldt_count_r - 32'h0000_0001;
            end
            if (hit_wr(`PRT_CTRL_OFS)) begin
                prt_rate_r <= pwdata_i[2:0] > 3'h6 ? 3'h6 : pwdata_i[2:0];
                prt_en_r <= pwdata_i[`PRT_CTRL_EN_BIT];
            end
            if (hit_wr(`TMR_IRQ_EN_OFS)) begin
                irq_en_r <= pwdata_i[1:0];
            end
            // Write one to clear; a new roll-over wins
            if (ldt_roll) begin
                ldt_flag_r <= 1'b1;
            end else if (hit_wr(`TMR_STATUS_OFS) &&
                pwdata_i[`TMR_STAT_LDT_BIT]) begin
                ldt_flag_r <= 1'b0;
            end
            if (prt_tick) begin
                prt_flag_r <= 1'b1;
            end else if (hit_wr(`TMR_STATUS_OFS) &&
                pwdata_i[`TMR_STAT_PRT_BIT]) begin
                prt_flag_r <= 1'b0;
            end
            timer_irq_o <= |({prt_flag_r, ldt_flag_r} & irq_en_r);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                `WD_CTRL_OFS: prdata_o <= {30'h0, wd_reset_mode_r, wd_run_r};
                `WD_TIMEOUT_OFS: prdata_o <= wd_timeout_r;
                `WD_STATUS_OFS: prdata_o <= {29'h0, wd_nmi_seen_r,
                    wd_active, wd_hw_enable_i};
                `LDT_HOLD_OFS: prdata_o <= ldt_hold_r;
                `LDT_CTRL_OFS: prdata_o <= {31'h0, ldt_run_r};
                `LDT_COUNT_OFS: prdata_o <= ldt_count_r;
                `PRT_CTRL_OFS: prdata_o <= {28'h0, prt_en_r, prt_rate_r};
                `TMR_STATUS_OFS: prdata_o <= {30'h0, prt_flag_r,
                    ldt_flag_r};
                `TMR_IRQ_EN_OFS: prdata_o <= {30'h0, irq_en_r};
                default: prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    wire unused_rd = rd;

endmodule // board_watchdog_and_timers

// File: shared/board_timers_map.vh
// Register map, field positions, reset values and timing counts
// for the board watchdog and timers block.
// Assumes a 10 MHz system clock and word-aligned APB byte addresses.
`ifndef BOARD_TIMERS_MAP_VH
`define BOARD_TIMERS_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define WD_CTRL_OFS 12'h000
`define WD_RESTART_OFS 12'h004
`define WD_TIMEOUT_OFS 12'h008
`define WD_STATUS_OFS 12'h00c
`define LDT_HOLD_OFS 12'h010
`define LDT_CTRL_OFS 12'h014
`define LDT_COUNT_OFS 12'h018
`define PRT_CTRL_OFS 12'h01c
`define TMR_STATUS_OFS 12'h020
`define TMR_IRQ_EN_OFS 12'h024

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WD_CTRL_RUN_BIT 0
`define WD_CTRL_RESET_MODE_BIT 1
`define WD_STAT_HW_EN_BIT 0
`define WD_STAT_RUN_BIT 1
`define WD_STAT_NMI_BIT 2
`define LDT_CTRL_START_BIT 0
`define PRT_CTRL_EN_BIT 3
`define TMR_STAT_LDT_BIT 0
`define TMR_STAT_PRT_BIT 1

// ----------------------------------------------------------------
// Reset values and keys
// ----------------------------------------------------------------
`define WD_TIMEOUT_RST 32'h000f_4240
`define WD_RESTART_KEY 32'h0000_5a5a
`define BOARD_RESET_PULSE_CYC 16

// ----------------------------------------------------------------
// Periodic rates in Hz, and the clock they divide
// ----------------------------------------------------------------
`define SYS_CLK_HZ 10000000
`define PRT_RATE_0_HZ 100
`define PRT_RATE_1_HZ 200
`define PRT_RATE_2_HZ 500
`define PRT_RATE_3_HZ 1000
`define PRT_RATE_4_HZ 2000
`define PRT_RATE_5_HZ 5000
`define PRT_RATE_6_HZ 10000

`endif

// File: design/rate_divider.v
// Periodic rate divider: one-cycle tick at the selected rate.
// Assumes the system clock in the map header and a 3-bit rate code.
`timescale 1ns/1ps
`include "board_timers_map.vh"

module rate_divider (
    // Clock and reset
    input wire sys_clk_i,
    input wire reset_i,
    // Control
    input wire enable_i,
    input wire [2:0] rate_sel_i,
    // Tick out
    output reg tick_o
);

    // ------------------------------------------------------------
    // Period lookup
    // ------------------------------------------------------------
    function [16:0] period_of;
        input [2:0] sel;
        reg [31:0] full;
        begin
            case (sel)
                3'h0: full = `SYS_CLK_HZ / `PRT_RATE_0_HZ;
                3'h1: full = `SYS_CLK_HZ / `PRT_RATE_1_HZ;
                3'h2: full = `SYS_CLK_HZ / `PRT_RATE_2_HZ;
                3'h3: full = `SYS_CLK_HZ / `PRT_RATE_3_HZ;
                3'h4: full = `SYS_CLK_HZ / `PRT_RATE_4_HZ;
                3'h5: full = `SYS_CLK_HZ / `PRT_RATE_5_HZ;
                default: full = `SYS_CLK_HZ / `PRT_RATE_6_HZ;
            endcase
            period_of = full[16:0];
        end
    endfunction

    reg [16:0] count_r;
    reg [2:0] sel_r;

    // ------------------------------------------------------------
    // Counter; restarts on rate change or disable
    // ------------------------------------------------------------
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_r <= 17'h00000;
            sel_r <= 3'h0;
            tick_o <= 1'b0;
        end else begin
            sel_r <= rate_sel_i;
            tick_o <= 1'b0;
            if (!enable_i || sel_r != rate_sel_i) begin
                count_r <= 17'h00000;
            end else if (count_r == period_of(rate_sel_i) - 17'h00001) begin
                count_r <= 17'h00000;
                tick_o <= 1'b1;
            end else begin
                count_r <= count_r + 17'h00001;
            end
        end
    end

endmodule // rate_divider

// File: testbench/board_timers_monitor.sv
// Port assertions for the board watchdog and timers block.
// Assumes binding to the top module; sees only its ports.
`timescale 1ns/1ps
`include "board_timers_map.vh"

module board_timers_monitor #(
    parameter RESET_PULSE_CYC = 16
) (
    input wire sys_clk_i,
    input wire reset_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire pready_o,
    input wire pslverr_o,
    input wire [31:0] prdata_o,
    input wire wd_hw_enable_i,
    input wire nmi_o,
    input wire board_reset_o,
    input wire timer_irq_o
);
    logic [7:0] len_r;
    wire acs = psel_i && penable_i;
    wire tmr_wr = acs && pwrite_i && (paddr_i == `TMR_STATUS_OFS
        || paddr_i == `TMR_IRQ_EN_OFS);
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i)
            len_r <= 8'h00;
        else if (board_reset_o)
            len_r <= len_r + 8'h01;
        else
            len_r <= 8'h00;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_pulse_end; $fell(board_reset_o); endsequence
    sequence s_irq_drop; $fell(timer_irq_o); endsequence
    a_ready_high: assert property (pready_o) else $error("pready low");
    a_err_access: assert property (!acs |-> !pslverr_o) else $error("err");
    a_unmapped_zero: assert property (acs && !pwrite_i && pslverr_o
        |-> prdata_o == 32'h0) else $error("unmapped data");
    a_nmi_level_holds: assert property (nmi_o && wd_hw_enable_i
        && !(acs && pwrite_i) |=> nmi_o) else $error("nmi dropped");
    a_off_no_nmi: assert property (!wd_hw_enable_i |=> !nmi_o)
        else $error("nmi while off");
    a_reset_needs_en: assert property ($rose(board_reset_o)
        |-> $past(wd_hw_enable_i)) else $error("reset while off");
    a_pulse_length: assert property (s_pulse_end
        |-> len_r == RESET_PULSE_CYC) else $error("pulse length");
    a_nmi_or_reset: assert property (!(nmi_o && board_reset_o))
        else $error("both actions");
    a_irq_clear_cause: assert property (s_irq_drop
        |-> $past(tmr_wr, 2) || $past(tmr_wr)) else $error("irq fell alone");
endmodule // board_timers_monitor

bind board_watchdog_and_timers board_timers_monitor #(
    .RESET_PULSE_CYC(RESET_PULSE_CYC)
) board_timers_monitor_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .prdata_o(prdata_o), .wd_hw_enable_i(wd_hw_enable_i), .nmi_o(nmi_o),
    .board_reset_o(board_reset_o), .timer_irq_o(timer_irq_o));

// File: testbench/board_watchdog_and_timers_tb.sv
// Testbench for the board watchdog and timers block.
// Assumes the map header and a 10 MHz clock; APB master is the bench.
`timescale 1ns/1ps
`include "board_timers_map.vh"

module board_watchdog_and_timers_tb;
    localparam int PULSE = 6;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic wd_hw_enable_i = 1'b1;
    wire pready_o;
    wire pslverr_o;
    wire [31:0] prdata_o;
    wire nmi_o;
    wire board_reset_o;
    wire timer_irq_o;
    logic [31:0] rd_v;
    logic err_v;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int len;
    int hz[7] = '{`PRT_RATE_0_HZ, `PRT_RATE_1_HZ, `PRT_RATE_2_HZ,
        `PRT_RATE_3_HZ, `PRT_RATE_4_HZ, `PRT_RATE_5_HZ, `PRT_RATE_6_HZ};

    board_watchdog_and_timers #(.RESET_PULSE_CYC(PULSE))
    board_watchdog_and_timers_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .prdata_o(prdata_o),
        .wd_hw_enable_i(wd_hw_enable_i), .nmi_o(nmi_o),
        .board_reset_o(board_reset_o), .timer_irq_o(timer_irq_o));

    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) cyc <= cyc + 1;

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic logic sig(input int s);
        return s == 0 ? timer_irq_o : (s == 1 ? nmi_o : board_reset_o);
    endfunction
    task automatic wait_hi(input int s, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end while (sig(s) !== 1'b1 && n < lim);
        if (sig(s) !== 1'b1) begin
            num_errors++;
            $display("ERROR wait expected 1 seen 0 on output %0d", s);
            test_done();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        int n;
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (pready_o !== 1'b1) begin
            num_errors++;
            $display("ERROR pready expected 1 seen 0");
            test_done();
        end
        rd_v = prdata_o;
        err_v = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic period(input logic [31:0] m, input int e);
        int t0;
        wait_hi(0, 2 * e + 100);
        t0 = cyc;
        apb(0, `TMR_STATUS_OFS, 0);
        chk("flag", rd_v & m, m);
        apb(1, `TMR_STATUS_OFS, m);
        repeat (2) @(posedge sys_clk_i);
        wait_hi(0, 2 * e + 100);
        chk("period", cyc - t0, e);
        apb(1, `TMR_STATUS_OFS, 3);
        $display("test period %0d done", e);
    endtask

    // ------------------------------------------------
    // Sequence
    // ------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        apb(0, `WD_TIMEOUT_OFS, 0);
        chk("timeout", rd_v, `WD_TIMEOUT_RST);
        apb(0, 12'h030, 0);
        chk("slverr", err_v, 1);
        chk("unmapped", rd_v, 0);
        apb(1, `WD_TIMEOUT_OFS, 40);
        apb(1, `WD_CTRL_OFS, 1);
        repeat (8) begin
            apb(1, `WD_RESTART_OFS, `WD_RESTART_KEY);
            repeat (20) @(posedge sys_clk_i);
            chk("quiet", {nmi_o, board_reset_o}, 0);
        end
        repeat (4) apb(1, `WD_RESTART_OFS, 32'h0000_a5a5);
        wait_hi(1, 100);
        apb(0, `WD_STATUS_OFS, 0);
        chk("status", rd_v & 7, 7);
        apb(1, `WD_RESTART_OFS, `WD_RESTART_KEY);
        repeat (2) @(posedge sys_clk_i);
        chk("nmi drop", nmi_o, 0);
        apb(1, `WD_STATUS_OFS, 4);
        apb(1, `WD_CTRL_OFS, 3);
        wait_hi(2, 100);
        len = 0;
        while (board_reset_o === 1'b1 && len < 300) begin
            @(posedge sys_clk_i);
            #1;
            len++;
        end
        chk("pulse", len, PULSE);
        chk("no nmi", nmi_o, 0);
        apb(1, `WD_CTRL_OFS, 0);
        $display("test watchdog done");
        wd_hw_enable_i <= 1'b0;
        apb(1, `WD_CTRL_OFS, 1);
        repeat (150) @(posedge sys_clk_i);
        chk("off", {nmi_o, board_reset_o}, 0);
        apb(0, `WD_STATUS_OFS, 0);
        chk("hw en", rd_v & 1, 0);
        apb(1, `WD_CTRL_OFS, 0);
        wd_hw_enable_i <= 1'b1;
        apb(1, `TMR_IRQ_EN_OFS, 1);
        apb(1, `LDT_HOLD_OFS, 50);
        apb(1, `LDT_CTRL_OFS, 1);
        period(1, 51);
        apb(1, `LDT_CTRL_OFS, 0);
        apb(1, `TMR_STATUS_OFS, 3);
        apb(1, `TMR_IRQ_EN_OFS, 2);
        for (int r = 2; r < 7; r++) begin
            apb(1, `PRT_CTRL_OFS, 8 | r);
            period(2, `SYS_CLK_HZ / hz[r]);
        end
        apb(1, `PRT_CTRL_OFS, 0);
        test_done();
    end
endmodule // board_watchdog_and_timers_tb
